// [pmt_pkg.sv]
/*
  package for the 8-bit period match timer: register map, field layout,
  reset values and carrier structs.
  assumes an apb slave with 32-bit data and one register per aligned word.
*/
`default_nettype none
package pmt_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam logic [4:0] OFF_COUNT   = 5'h00;
  localparam logic [4:0] OFF_CONTROL = 5'h04;
  localparam logic [4:0] OFF_PERIOD  = 5'h08;
  localparam logic [4:0] OFF_STATUS  = 5'h0C;
  localparam logic [4:0] OFF_MASK    = 5'h10;

  localparam logic [7:0] COUNT_RST   = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST  = 8'hFF;
  localparam logic [7:0] CONTROL_WMASK = 8'h7F;

  localparam int unsigned PRE_LSB  = 0;
  localparam int unsigned RUN_BIT  = 2;
  localparam int unsigned POST_LSB = 3;
  localparam int unsigned IRQ_BIT  = 1;

  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;
  localparam logic [3:0] PRE_TOP1  = 4'h0;
  localparam logic [3:0] PRE_TOP4  = 4'h3;
  localparam logic [3:0] PRE_TOP16 = 4'hF;

  typedef struct packed {
    logic       match;
    logic [7:0] count;
  } pmt_base_s;

  typedef struct packed {
    logic        sel;
    logic        en;
    logic        wr;
    logic [4:0]  addr;
    logic [31:0] wdata;
  } pmt_apb_req_s;
endpackage
`default_nettype wire

// [pmt_timer.sv]
/*
  8-bit period match timer with prescaler, postscaler, sticky interrupt
  status and an apb register slave.
  assumes apb master signalling, single clock ref_clk, async active-low rst_b;
  the instruction-cycle tick arrives as a one-cycle strobe.
*/
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - prescaler feeds counter from instruction clock
// - select 00 div1, 01 div4, 1x div16
// - count up, wrap to zero after match
// - period register read/write, resets to FFh
// - count register read/write, reset zero
// - postscaler emits event every N matches
// - postscale ratio bits 6:3 plus one
// - postscaler event sets interrupt flag bit 1
// - count/control writes and reset clear scalers
// - control write keeps count value
// - run bit 2 enables counting
// - control bit 7 reads zero
// - raw match pulse to serial port
// - count and match to pwm unit
module pmt_timer #(
  parameter int unsigned PRE_W  = 4,
  parameter int unsigned POST_W = 4
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic              instr_tick,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  output logic                   sync_serial_tick,
  output pmt_pkg::pmt_base_s     pwm_base,
  output logic                   irq
);
  pmt_pkg::pmt_apb_req_s req;
  logic [7:0] count_q, count_d;
  logic [7:0] control_q;
  logic [7:0] period_q;
  logic [3:0] pre_q, pre_d;
  logic [3:0] post_q, post_d;
  logic [7:0] status_q;
  logic [7:0] mask_q;
  logic [31:0] prdata_q;

  // scaler widths are fixed by the select fields; other sizes are refused
  if (PRE_W != 4 || POST_W != 4) begin : g_bad_width
    $error("scaler width must be 4");
  end

  assign req = '{sel: psel, en: penable, wr: pwrite,
                 addr: paddr[pmt_pkg::ADDR_W-1:0], wdata: pwdata};

  // apb decode; one wait-free access phase
  wire acc      = req.sel & req.en;
  wire lane0    = pstrb[0];
  wire hit_cnt  = req.addr == pmt_pkg::OFF_COUNT;
  wire hit_ctl  = req.addr == pmt_pkg::OFF_CONTROL;
  wire hit_per  = req.addr == pmt_pkg::OFF_PERIOD;
  wire hit_sts  = req.addr == pmt_pkg::OFF_STATUS;
  wire hit_msk  = req.addr == pmt_pkg::OFF_MASK;
  wire hit_any  = hit_cnt | hit_ctl | hit_per | hit_sts | hit_msk;
  wire aligned  = paddr[1:0] == 2'h0 && paddr[31:pmt_pkg::ADDR_W] == '0;
  wire mapped   = hit_any & aligned;
  wire wr_cnt   = acc & req.wr & mapped & hit_cnt & lane0;
  wire wr_ctl   = acc & req.wr & mapped & hit_ctl & lane0;
  wire wr_per   = acc & req.wr & mapped & hit_per & lane0;
  wire wr_msk   = acc & req.wr & mapped & hit_msk & lane0;
  wire rd_sts   = acc & ~req.wr & mapped & hit_sts;

  // control fields
  wire [1:0] pre_sel  = control_q[pmt_pkg::PRE_LSB +: 2];
  wire       run      = control_q[pmt_pkg::RUN_BIT];
  wire [3:0] post_sel = control_q[pmt_pkg::POST_LSB +: 4];

  wire [3:0] pre_top  = (pre_sel == pmt_pkg::PRE_DIV1) ? pmt_pkg::PRE_TOP1 :
                        (pre_sel == pmt_pkg::PRE_DIV4) ? pmt_pkg::PRE_TOP4 :
                        pmt_pkg::PRE_TOP16;
  wire       tick     = run & instr_tick & (pre_q >= pre_top);
  wire       match    = tick & (count_q == period_q);
  wire       post_evt = match & (post_q == post_sel);

  always_comb begin
    pre_d = pre_q;
    if (run & instr_tick) begin
      pre_d = (pre_q >= pre_top) ? 4'h0 : 4'(pre_q + 4'h1);
    end
    if (wr_cnt | wr_ctl) begin
      pre_d = 4'h0;
    end
  end

  always_comb begin
    post_d = post_q;
    if (match) begin
      post_d = post_evt ? 4'h0 : 4'(post_q + 4'h1);
    end
    if (wr_cnt | wr_ctl) begin
      post_d = 4'h0;
    end
  end

  always_comb begin
    count_d = count_q;
    if (tick) begin
      count_d = match ? 8'h00 : 8'(count_q + 8'h01);
    end
    if (wr_cnt) begin
      count_d = req.wdata[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= pmt_pkg::COUNT_RST;
      pre_q   <= 4'h0;
      post_q  <= 4'h0;
    end else begin
      count_q <= count_d;
      pre_q   <= pre_d;
      post_q  <= post_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      control_q <= pmt_pkg::CONTROL_RST;
      period_q  <= pmt_pkg::PERIOD_RST;
      mask_q    <= 8'h00;
    end else begin
      if (wr_ctl) begin
        control_q <= req.wdata[7:0] & pmt_pkg::CONTROL_WMASK;
      end
      if (wr_per) begin
        period_q <= req.wdata[7:0];
      end
      if (wr_msk) begin
        mask_q <= req.wdata[7:0];
      end
    end
  end

  // read clears status; a new event in the same cycle wins
  // only bits already reported at setup are cleared, so no event is lost
  wire [7:0] evt_vec = 8'(post_evt) << pmt_pkg::IRQ_BIT;
  wire [7:0] clr_vec = rd_sts ? prdata_q[7:0] : 8'h00;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= 8'h00;
    end else begin
      status_q <= (status_q & ~clr_vec) | evt_vec;
    end
  end

  wire [7:0] rd_byte = hit_cnt ? count_q :
                       hit_ctl ? control_q :
                       hit_per ? period_q :
                       hit_sts ? status_q :
                       hit_msk ? mask_q : 8'h00;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_q <= 32'h0000_0000;
    end else if (req.sel & ~req.en & ~req.wr) begin
      prdata_q <= {24'h00_0000, rd_byte};
    end
  end

  assign pready           = 1'b1;
  assign pslverr          = acc & ~mapped;
  assign prdata           = prdata_q;
  assign sync_serial_tick = match;
  assign pwm_base         = '{match: match, count: count_q};
  assign irq              = |(status_q & mask_q);

  // assertions
  property p_wrap;
    @(posedge ref_clk) disable iff (!rst_b)
      (match && !wr_cnt) |=> count_q == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap after match");

  property p_step;
    @(posedge ref_clk) disable iff (!rst_b)
      (tick && !match && !wr_cnt) |=> count_q == $past(count_q) + 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("count did not step on tick");

  property p_hold_off;
    @(posedge ref_clk) disable iff (!rst_b)
      (!run && !wr_cnt) |=> $stable(count_q);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("count moved while stopped");

  property p_ctl_keeps;
    @(posedge ref_clk) disable iff (!rst_b)
      wr_ctl |=> (pre_q == 4'h0 && post_q == 4'h0 && count_q == $past(count_d));
  endproperty
  a_ctl_keeps: assert property (p_ctl_keeps) else $error("control write scaler clear wrong");

  property p_bit7;
    @(posedge ref_clk) disable iff (!rst_b)
      control_q[7] == 1'b0;
  endproperty
  a_bit7: assert property (p_bit7) else $error("control bit 7 set");

  property p_flag;
    @(posedge ref_clk) disable iff (!rst_b)
      post_evt |=> status_q[pmt_pkg::IRQ_BIT];
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set by postscaler");

  property p_div1;
    @(posedge ref_clk) disable iff (!rst_b)
      (run && instr_tick && pre_sel == pmt_pkg::PRE_DIV1) |-> tick;
  endproperty
  a_div1: assert property (p_div1) else $error("div1 missed a tick");

  property p_irq;
    @(posedge ref_clk) disable iff (!rst_b)
      irq |-> (status_q[pmt_pkg::IRQ_BIT] && mask_q[pmt_pkg::IRQ_BIT]) || |(status_q & mask_q);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without enabled flag");

  property p_post1;
    @(posedge ref_clk) disable iff (!rst_b)
      (match && post_sel == 4'h0 && post_q == 4'h0) |-> post_evt;
  endproperty
  a_post1: assert property (p_post1) else $error("1:1 postscale missed");

  property p_post16;
    @(posedge ref_clk) disable iff (!rst_b)
      (match && post_sel == 4'hF && post_q == 4'hF) |-> post_evt;
  endproperty
  a_post16: assert property (p_post16) else $error("1:16 postscale missed");

  property p_post_bound;
    @(posedge ref_clk) disable iff (!rst_b)
      post_q <= post_sel;
  endproperty
  a_post_bound: assert property (p_post_bound) else $error("postscaler passed its ratio");

  property p_post_step;
    @(posedge ref_clk) disable iff (!rst_b)
      (match && !post_evt && !wr_cnt && !wr_ctl) |=> post_q == $past(post_q) + 4'h1;
  endproperty
  a_post_step: assert property (p_post_step) else $error("postscaler did not count match");

  property p_stop_tick;
    @(posedge ref_clk) disable iff (!rst_b)
      !run |-> !tick;
  endproperty
  a_stop_tick: assert property (p_stop_tick) else $error("tick while stopped");

  property p_div4;
    @(posedge ref_clk) disable iff (!rst_b)
      (tick && pre_sel == pmt_pkg::PRE_DIV4) |-> pre_q == pmt_pkg::PRE_TOP4;
  endproperty
  a_div4: assert property (p_div4) else $error("div4 tick off its slot");

  property p_div16;
    @(posedge ref_clk) disable iff (!rst_b)
      (tick && pre_sel[1]) |-> pre_q == pmt_pkg::PRE_TOP16;
  endproperty
  a_div16: assert property (p_div16) else $error("div16 tick off its slot");

  property p_cnt_clear;
    @(posedge ref_clk) disable iff (!rst_b)
      wr_cnt |=> (pre_q == 4'h0 && post_q == 4'h0 && count_q == $past(pwdata[7:0]));
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("count write scaler clear wrong");

  property p_wr_per;
    @(posedge ref_clk) disable iff (!rst_b)
      wr_per |=> period_q == $past(pwdata[7:0]);
  endproperty
  a_wr_per: assert property (p_wr_per) else $error("period write lost");

  property p_per_hold;
    @(posedge ref_clk) disable iff (!rst_b)
      !wr_per |=> $stable(period_q);
  endproperty
  a_per_hold: assert property (p_per_hold) else $error("period changed without write");

  property p_ctl_hold;
    @(posedge ref_clk) disable iff (!rst_b)
      !wr_ctl |=> $stable(control_q);
  endproperty
  a_ctl_hold: assert property (p_ctl_hold) else $error("control changed without write");

  property p_cnt_rd;
    @(posedge ref_clk) disable iff (!rst_b)
      (req.sel && !req.en && !req.wr && hit_cnt) |=> prdata[7:0] == $past(count_q);
  endproperty
  a_cnt_rd: assert property (p_cnt_rd) else $error("count read data wrong");

  property p_ctl_rd;
    @(posedge ref_clk) disable iff (!rst_b)
      (req.sel && !req.en && !req.wr && hit_ctl) |=> prdata[7] == 1'b0;
  endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control bit 7 read as one");

  property p_sticky;
    @(posedge ref_clk) disable iff (!rst_b)
      (status_q[pmt_pkg::IRQ_BIT] && !rd_sts) |=> status_q[pmt_pkg::IRQ_BIT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without read");

  property p_rd_clear;
    @(posedge ref_clk) disable iff (!rst_b)
      (rd_sts && prdata_q[pmt_pkg::IRQ_BIT] && !post_evt) |=> !status_q[pmt_pkg::IRQ_BIT];
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("status read did not clear flag");

  property p_no_spur;
    @(posedge ref_clk) disable iff (!rst_b)
      (!post_evt && !status_q[pmt_pkg::IRQ_BIT]) |=> !status_q[pmt_pkg::IRQ_BIT];
  endproperty
  a_no_spur: assert property (p_no_spur) else $error("flag set without event");

  property p_sts_only;
    @(posedge ref_clk) disable iff (!rst_b)
      (status_q & ~(8'h01 << pmt_pkg::IRQ_BIT)) == 8'h00;
  endproperty
  a_sts_only: assert property (p_sts_only) else $error("unused status bit set");

  property p_irq_mask;
    @(posedge ref_clk) disable iff (!rst_b)
      !mask_q[pmt_pkg::IRQ_BIT] |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while disabled");

  c_match: cover property (@(posedge ref_clk) disable iff (!rst_b) match);
  c_irq:   cover property (@(posedge ref_clk) disable iff (!rst_b) irq);
  c_div16: cover property (@(posedge ref_clk) disable iff (!rst_b) tick && pre_sel[1]);
  c_post16: cover property (@(posedge ref_clk) disable iff (!rst_b) post_evt && post_sel == 4'hF);
  c_rd_clr: cover property (@(posedge ref_clk) disable iff (!rst_b) rd_sts && prdata_q[pmt_pkg::IRQ_BIT]);
endmodule
`default_nettype wire

// [period_match_timer_8bit_tb.sv]
/*
  self-checking bench for the period match timer: apb registers, prescale and
  postscale spans, sticky interrupt with mask.
  assumes pmt_pkg and pmt_timer compiled first; slave answers with zero waits.
*/
`timescale 1ns/100ps
`default_nettype none
module period_match_timer_8bit_tb;
  logic               ref_clk, rst_b, instr_tick, psel, penable, pwrite;
  logic [31:0]        paddr, pwdata, prdata;
  logic [3:0]         pstrb;
  logic               pready, pslverr, sst, irq;
  pmt_pkg::pmt_base_s pwm_base;
  logic [32:0]        expq[$];
  logic [32:0]        e;
  int                 miscompares, n_tests;

  pmt_timer dut (.ref_clk(ref_clk), .rst_b(rst_b), .instr_tick(instr_tick), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .sync_serial_tick(sst),
    .pwm_base(pwm_base), .irq(irq));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic test_done;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [32:0] ex, logic [32:0] got);
    n_tests++;
    if (got !== ex) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // request held until pready is sampled high
  task automatic xfer(logic w, logic [4:0] a, logic [31:0] d);
    int k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {27'h0, a};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      miscompares++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [4:0] a, logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(logic [4:0] a, logic [32:0] ex);
    expq.push_back(ex);
    xfer(1'b0, a, 32'h0);
  endtask

  // bit 32 of a note means only the error response is judged
  always @(posedge ref_clk) begin
    if (psel && penable && pready && !pwrite && expq.size() > 0) begin
      e = expq.pop_front();
      if (e[32]) chk("pslverr", 33'h1, {32'h0, pslverr});
      else chk("prdata", e, {pslverr, prdata});
    end
  end

  // clocks between two raw match pulses, sampled off the launching edge
  task automatic span(input int p, output int c);
    int k = 0;
    @(negedge ref_clk);
    while (sst !== 1'b1 && k < 900) begin
      @(negedge ref_clk);
      k++;
    end
    c = 0;
    do begin
      @(negedge ref_clk);
      c++;
    end while (sst !== 1'b1 && c < 900);
    chk("pwm_match", {32'h0, sst}, {32'h0, pwm_base.match});
    chk("pwm_count", 33'(p), {25'h0, pwm_base.count});
  endtask

  initial begin
    int p, c, n, i;
    logic [7:0] v;
    logic [3:0] ps [3];
    void'($urandom(52));
    ps = '{4'h0, 4'h1, 4'hF};
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    instr_tick = 1'b1;
    pstrb = 4'hF;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(pmt_pkg::OFF_COUNT, 33'h0);
    rd(pmt_pkg::OFF_CONTROL, 33'h0);
    rd(pmt_pkg::OFF_PERIOD, 33'hFF);
    rd(pmt_pkg::OFF_STATUS, 33'h0);
    rd(pmt_pkg::OFF_MASK, 33'h0);
    wr(pmt_pkg::OFF_CONTROL, 32'hFF);
    rd(pmt_pkg::OFF_CONTROL, 33'h7F);
    wr(pmt_pkg::OFF_CONTROL, 32'h0);
    wr(pmt_pkg::OFF_COUNT, 32'h37);
    repeat (10) @(posedge ref_clk);
    rd(pmt_pkg::OFF_COUNT, 33'h37);
    wr(pmt_pkg::OFF_CONTROL, 32'h7B);
    rd(pmt_pkg::OFF_COUNT, 33'h37);
    v = 8'($urandom());
    wr(pmt_pkg::OFF_PERIOD, {24'h0, v});
    rd(pmt_pkg::OFF_PERIOD, {25'h0, v});
    rd(5'h14, 33'h100000000);
    rd(5'h02, 33'h100000000);
    for (i = 0; i < 4; i++) begin
      p = (i == 0) ? 0 : $urandom_range(3, 1);
      wr(pmt_pkg::OFF_PERIOD, 32'(p));
      wr(pmt_pkg::OFF_COUNT, 32'h0);
      wr(pmt_pkg::OFF_CONTROL, 32'h4 | 32'(i));
      span(p, c);
      chk("span", 33'(((i == 0) ? 1 : (i == 1) ? 4 : 16) * (p + 1)), 33'(c));
    end
    wr(pmt_pkg::OFF_CONTROL, 32'h0);
    rd(pmt_pkg::OFF_STATUS, 33'h2);
    wr(pmt_pkg::OFF_MASK, 32'h2);
    wr(pmt_pkg::OFF_PERIOD, 32'h2);
    foreach (ps[j]) begin
      wr(pmt_pkg::OFF_COUNT, 32'h0);
      wr(pmt_pkg::OFF_CONTROL, 32'h4 | (32'(ps[j]) << 3));
      n = 0;
      for (c = 0; c < 300; c++) begin
        @(negedge ref_clk);
        if (irq === 1'b1) break;
        if (sst === 1'b1) n++;
      end
      chk("post_matches", 33'(ps[j]) + 33'h1, 33'(n));
      wr(pmt_pkg::OFF_CONTROL, 32'h0);
      rd(pmt_pkg::OFF_STATUS, 33'h2);
      @(negedge ref_clk);
      chk("irq", 33'h0, {32'h0, irq});
    end
    wr(pmt_pkg::OFF_MASK, 32'h0);
    wr(pmt_pkg::OFF_CONTROL, 32'h4);
    repeat (20) @(negedge ref_clk);
    chk("irq", 33'h0, {32'h0, irq});
    wr(pmt_pkg::OFF_CONTROL, 32'h0);
    wr(pmt_pkg::OFF_MASK, 32'h2);
    @(negedge ref_clk);
    chk("irq", 33'h1, {32'h0, irq});
    rd(pmt_pkg::OFF_STATUS, 33'h2);
    @(negedge ref_clk);
    chk("irq", 33'h0, {32'h0, irq});
    test_done();
  end

  // the whole sequence needs under a thousand clocks
  initial begin
    #400000;
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
